// >>> oscsw_ctrl.sv
// Purpose: oscillator source switch sequencer with divider and trim registers on apb
// Assumes: fuses stable after reset; analog status inputs are asynchronous and synchronised here
// Notes:   one-wait apb slave, unmapped addresses read zero and answer pslverr
// Summary of operation
// - secondary oscillator runs while its enable is set or while it is selected
// - software sets switch request; device clears it when the switch completes
// - with recover on irq set, an interrupt clears ratio apply enable
// - three-bit ratio divides by two to the code, reset code 011
// - ratio apply enable selects divided ratio, otherwise 1:1
// - rc postscaler codes 000-110 divide by powers of two, 111 by 256
// - vco divider 00 /2, 01 /4 reset, 11 /8, 10 reserved
// - phase input divider divides by value plus two, reset 00000
// - feedback multiplier is value plus two, reset 000110000
// - rc trim is a signed six-bit offset, reset zero
// - primary submode comes only from fuses, never changed at run time
// - switching enabled only when the switching disable fuse is 0
// - while disabled, current source shows reset fuse and request stays 0
// - equal current and next sources clear the request and abort
// - a valid switch clears pll settled status and clock fail flag
// - start new oscillator, wait for crystal ready and pll settled when used
// - count 10 new-clock cycles before moving the system clock
// - on completion clear request and copy next into current source
// - stop old oscillator, keep low power rc and secondary as needed
// - source fields share the eight-code encoding
// - freeze bit with freeze fuse blocks clock and pll changes
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module oscsw_ctrl
  import oscsw_pkg::*;
(
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // fuses and analog status
  input  wire oscsw_pkg::oscsw_fuse_t fuse,
  input  wire oscsw_pkg::oscsw_ana_t  ana,
  // oscillator controls
  output oscsw_pkg::oscsw_ctl_t   ctl
);
  import oscsw_pkg::*;

  typedef struct packed {
    oscsw_st_t  st;
    logic       loaded;
    oscsw_src_t cur;
    oscsw_src_t nxt;
    logic       frz;
    logic       lck;
    logic       cf;
    logic       sec;
    logic       swr;
    logic       recover_on_irq;
    logic [2:0] rat;
    logic       rae;
    logic [2:0] rcp;
    logic [1:0] vco;
    logic [4:0] pre;
    logic [8:0] fbm;
    logic [5:0] trm;
    logic       unl_lo;
    logic       unl_hi;
    logic [3:0] cnt;
    oscsw_ana_t sy1;
    oscsw_ana_t sy2;
    logic       tick_d;
    logic       irq_d;
    logic [31:0] rdata;
    logic        err;
    logic        rdy;
    oscsw_ctl_t  ctl;
  } oscsw_state_t;

  oscsw_state_t s_r;
  oscsw_state_t s_nxt;

  logic        wr;
  logic        rd;
  logic        sw_en;
  logic        frozen;
  logic        new_pll;
  logic        tick;
  logic        irq_pulse;
  oscsw_src_t  src;

  // bus decode and strap-derived conditions
  // writes land on the completing edge; read data and error are captured one cycle earlier
  assign wr        = psel && penable && pwrite && s_r.rdy;
  assign rd        = psel && penable && !s_r.rdy;
  assign sw_en     = !fuse.switching_disable_fuse;
  assign frozen    = s_r.frz && fuse.freeze_fuse;
  assign new_pll   = (s_r.nxt == OSCSW_SRC_FAST_RC_WITH_PLL) || (s_r.nxt == OSCSW_SRC_PRIPLL);
  assign tick      = s_r.sy2.new_clk_tick && !s_r.tick_d;
  assign irq_pulse = s_r.sy2.irq && !s_r.irq_d;
  assign src       = sw_en ? s_r.cur : fuse.reset_source_fuse;

  // next-state logic for registers, sequencer and outputs
  always_comb
  begin
    s_nxt        = s_r;
    s_nxt.sy1    = ana;
    s_nxt.sy2    = s_r.sy1;
    s_nxt.tick_d = s_r.sy2.new_clk_tick;
    s_nxt.irq_d  = s_r.sy2.irq;
    s_nxt.err    = 1'b0;
    s_nxt.rdy    = psel && penable && !s_r.rdy;                    // one wait state
    if (!s_r.loaded)
    begin
      s_nxt.loaded = 1'b1;
      s_nxt.cur    = fuse.reset_source_fuse;
      s_nxt.nxt    = fuse.reset_source_fuse;
    end
    if (s_r.sy2.pll_locked && s_r.st != OSCSW_CHECK)
      s_nxt.lck = 1'b1;
    // apb writes
    if (wr)
    begin
      unique case (paddr)
        OSCSW_UNLOCK_OFF:
        begin
          if (pwdata[31:8] == OSCSW_UNLOCK_KEY[31:8])
          begin
            s_nxt.unl_lo = pwdata[0];
            s_nxt.unl_hi = pwdata[1];
          end
        end
        OSCSW_OSC_CTRL_OFF:
        begin
          if (s_r.unl_hi && !frozen)
            s_nxt.nxt = oscsw_src_t'(pwdata[OSCSW_NXT_LSB +: 3]);
          if (s_r.unl_lo)
          begin
            if (!frozen)
            begin
              s_nxt.frz = pwdata[OSCSW_FRZ_BIT] | s_r.frz;
              s_nxt.swr = (pwdata[OSCSW_SWR_BIT] && sw_en) | s_r.swr;
            end
            s_nxt.sec = pwdata[OSCSW_SEC_BIT];
            if (!pwdata[OSCSW_CF_BIT])
              s_nxt.cf = 1'b0;
          end
          s_nxt.unl_lo = 1'b0;
          s_nxt.unl_hi = 1'b0;
        end
        OSCSW_CLK_DIV_OFF:
        begin
          s_nxt.recover_on_irq = pwdata[OSCSW_ROI_BIT];
          s_nxt.rat = pwdata[OSCSW_RAT_LSB +: 3];
          s_nxt.rae = pwdata[OSCSW_RAE_BIT];
          if (!frozen)
          begin
            s_nxt.rcp = pwdata[OSCSW_RCP_LSB +: 3];
            if (pwdata[OSCSW_VCO_LSB +: 2] != OSCSW_VCO_RSV)
              s_nxt.vco = pwdata[OSCSW_VCO_LSB +: 2];
            s_nxt.pre = pwdata[OSCSW_PRE_LSB +: 5];
          end
        end
        OSCSW_PLL_FBD_OFF:
        begin
          if (!frozen)
            s_nxt.fbm = pwdata[8:0];
        end
        OSCSW_RC_TRIM_OFF:
          s_nxt.trm = pwdata[5:0];
        OSCSW_STATUS_OFF:
          s_nxt.err = 1'b0;
        default:
          s_nxt.err = 1'b0;                                        // error already flagged in the wait cycle
      endcase
    end
    // interrupt recovery
    if (s_r.recover_on_irq && irq_pulse)
      s_nxt.rae = 1'b0;
    // clock failure flag, set wins over a clear
    if (s_r.sy2.clock_fail && sw_en)
      s_nxt.cf = 1'b1;
    // switch sequencer
    unique case (s_r.st)
      OSCSW_IDLE:
        if (s_r.swr && sw_en)
          s_nxt.st = OSCSW_CHECK;
      OSCSW_CHECK:
      begin
        if (s_r.cur == s_r.nxt)
        begin
          s_nxt.swr = 1'b0;
          s_nxt.st  = OSCSW_IDLE;
        end
        else
        begin
          s_nxt.lck = 1'b0;
          s_nxt.cf  = s_r.sy2.clock_fail;
          s_nxt.st  = OSCSW_START;
        end
      end
      OSCSW_START:
      begin
        s_nxt.cnt = 4'h0;
        if ((s_r.nxt == OSCSW_SRC_PRI || s_r.nxt == OSCSW_SRC_PRIPLL) && !s_r.sy2.pri_ready)
          s_nxt.st = OSCSW_START;
        else if (s_r.nxt == OSCSW_SRC_SEC && !s_r.sy2.sec_ready)
          s_nxt.st = OSCSW_START;
        else if (new_pll && !s_r.lck)
          s_nxt.st = OSCSW_START;
        else
          s_nxt.st = OSCSW_SETTLE;
      end
      OSCSW_SETTLE:
      begin
        if (tick)
          s_nxt.cnt = s_r.cnt + 4'h1;
        if (tick && s_r.cnt == OSCSW_SETTLE_CYC - 4'h1)
          s_nxt.st = OSCSW_COMMIT;
      end
      OSCSW_COMMIT:
      begin
        s_nxt.cur = s_r.nxt;
        s_nxt.swr = 1'b0;
        s_nxt.st  = OSCSW_IDLE;
      end
      default:
        s_nxt.st = OSCSW_IDLE;
    endcase
    if (!sw_en)
      s_nxt.swr = 1'b0;
    // apb read data
    s_nxt.rdata = 32'h0000_0000;
    if (rd)
    begin
      unique case (paddr)
        OSCSW_OSC_CTRL_OFF:
        begin
          s_nxt.rdata[OSCSW_CUR_LSB +: 3] = src;
          s_nxt.rdata[OSCSW_NXT_LSB +: 3] = s_r.nxt;
          s_nxt.rdata[OSCSW_FRZ_BIT]      = s_r.frz;
          s_nxt.rdata[OSCSW_LCK_BIT]      = s_r.lck;
          s_nxt.rdata[OSCSW_CF_BIT]       = s_r.cf;
          s_nxt.rdata[OSCSW_SEC_BIT]      = s_r.sec;
          s_nxt.rdata[OSCSW_SWR_BIT]      = s_r.swr;
        end
        OSCSW_CLK_DIV_OFF:
          s_nxt.rdata[15:0] = {s_r.recover_on_irq, s_r.rat, s_r.rae, s_r.rcp, s_r.vco, 1'b0, s_r.pre};
        OSCSW_PLL_FBD_OFF:
          s_nxt.rdata[8:0] = s_r.fbm;
        OSCSW_RC_TRIM_OFF:
          s_nxt.rdata[5:0] = s_r.trm;
        OSCSW_UNLOCK_OFF:
          s_nxt.rdata[1:0] = {s_r.unl_hi, s_r.unl_lo};
        OSCSW_STATUS_OFF:
          s_nxt.rdata[2:0] = s_r.st;
        default:
          s_nxt.err = 1'b1;
      endcase
    end
    // oscillator enables and divider outputs
    s_nxt.ctl.sys_src             = src;
    s_nxt.ctl.pri_submode         = fuse.primary_submode_fuse;
    s_nxt.ctl.proc_ratio          = s_r.rae ? s_r.rat : 3'h0;
    s_nxt.ctl.rc_postscale        = s_r.rcp;
    s_nxt.ctl.vco_out_divider     = s_r.vco;
    s_nxt.ctl.phase_input_divider = s_r.pre;
    s_nxt.ctl.feedback_multiplier = s_r.fbm;
    s_nxt.ctl.rc_trim             = s_r.trm;
    s_nxt.ctl.sec_en  = s_r.sec || src == OSCSW_SRC_SEC
                        || (s_r.st != OSCSW_IDLE && s_r.nxt == OSCSW_SRC_SEC);
    s_nxt.ctl.low_power_rc_osc_en = fuse.wdt_enable || sw_en || src == OSCSW_SRC_LOW_POWER_RC_OSC
                        || (s_r.st != OSCSW_IDLE && s_r.nxt == OSCSW_SRC_LOW_POWER_RC_OSC);
    s_nxt.ctl.pri_en  = src inside {OSCSW_SRC_PRI, OSCSW_SRC_PRIPLL}
                        || (s_r.st != OSCSW_IDLE && s_r.nxt inside {OSCSW_SRC_PRI, OSCSW_SRC_PRIPLL});
    s_nxt.ctl.fast_rc_en = src inside {OSCSW_SRC_FRC, OSCSW_SRC_FAST_RC_WITH_PLL, OSCSW_SRC_FRC16, OSCSW_SRC_FRCN}
                        || (s_r.st != OSCSW_IDLE && s_r.nxt inside {OSCSW_SRC_FRC, OSCSW_SRC_FAST_RC_WITH_PLL,
                                                                     OSCSW_SRC_FRC16, OSCSW_SRC_FRCN});
    s_nxt.ctl.pll_en  = src inside {OSCSW_SRC_FAST_RC_WITH_PLL, OSCSW_SRC_PRIPLL} || (s_r.st != OSCSW_IDLE && new_pll);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r     <= '0;
      s_r.rat <= OSCSW_RAT_RST;
      s_r.rcp <= OSCSW_RCP_RST;
      s_r.vco <= OSCSW_VCO_RST;
      s_r.pre <= OSCSW_PRE_RST;
      s_r.fbm <= OSCSW_FBM_RST;
      s_r.trm <= OSCSW_TRM_RST;
      s_r.st  <= OSCSW_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  // outputs straight from flops; one wait state so read data stands with pready
  assign prdata  = s_r.rdata;
  assign pslverr = s_r.err;
  assign ctl     = s_r.ctl;
  assign pready  = s_r.rdy;

  // assertions
  property p_abort_equal;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == OSCSW_CHECK && s_r.cur == s_r.nxt) |=> (!s_r.swr && s_r.st == OSCSW_IDLE);
  endproperty
  a_abort_equal: assert property (p_abort_equal) else $error("redundant switch not aborted");

  property p_clear_status;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == OSCSW_CHECK && s_r.cur != s_r.nxt) |=> (!s_r.lck && s_r.st == OSCSW_START);
  endproperty
  a_clear_status: assert property (p_clear_status) else $error("lock status not cleared");

  property p_commit;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == OSCSW_COMMIT) |=> (s_r.cur == $past(s_r.nxt) && !s_r.swr);
  endproperty
  a_commit: assert property (p_commit) else $error("commit did not update current source");

  property p_settle;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == OSCSW_SETTLE && $past(s_r.st) != OSCSW_SETTLE) |-> s_r.cnt == 4'h0;
  endproperty
  a_settle: assert property (p_settle) else $error("settle count not restarted");

  property p_disabled;
    @(posedge pclk) disable iff (!presetn)
      fuse.switching_disable_fuse |=> ##1 (!s_r.swr && ctl.sys_src == $past(fuse.reset_source_fuse, 2));
  endproperty
  a_disabled: assert property (p_disabled) else $error("switch active while disabled");

  property p_recover;
    @(posedge pclk) disable iff (!presetn)
      (s_r.recover_on_irq && irq_pulse) |=> !s_r.rae ##1 ctl.proc_ratio == 3'h0;
  endproperty
  a_recover: assert property (p_recover) else $error("interrupt did not recover ratio");

  property p_ratio;
    @(posedge pclk) disable iff (!presetn)
      !s_r.rae |=> ctl.proc_ratio == 3'h0;
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio not forced to 1:1");

  property p_locked_write;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == OSCSW_OSC_CTRL_OFF && !s_r.unl_hi && s_r.st == OSCSW_IDLE) |=> $stable(s_r.nxt);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("unlocked write accepted");

  property p_sec;
    @(posedge pclk) disable iff (!presetn)
      s_r.sec |=> ctl.sec_en;
  endproperty
  a_sec: assert property (p_sec) else $error("secondary oscillator not running");
endmodule
`default_nettype wire

// >>> oscsw_pkg.sv
// Purpose: shared constants and types for the oscillator switch and divider control block
// Assumes: 32-bit apb data, registers one aligned word each
// Notes:   register offsets are byte addresses
package oscsw_pkg;
  // register byte offsets
  localparam logic [11:0] OSCSW_OSC_CTRL_OFF  = 12'h000;
  localparam logic [11:0] OSCSW_CLK_DIV_OFF   = 12'h004;
  localparam logic [11:0] OSCSW_PLL_FBD_OFF   = 12'h008;
  localparam logic [11:0] OSCSW_RC_TRIM_OFF   = 12'h00C;
  localparam logic [11:0] OSCSW_UNLOCK_OFF    = 12'h010;
  localparam logic [11:0] OSCSW_STATUS_OFF    = 12'h014;
  // unlock key written to the unlock register, bit 0 arms the low byte, bit 1 the high byte
  localparam logic [31:0] OSCSW_UNLOCK_KEY    = 32'h0000_A500;
  // oscillator control field positions
  localparam int OSCSW_CUR_LSB  = 12;
  localparam int OSCSW_NXT_LSB  = 8;
  localparam int OSCSW_FRZ_BIT  = 7;
  localparam int OSCSW_LCK_BIT  = 5;
  localparam int OSCSW_CF_BIT   = 3;
  localparam int OSCSW_SEC_BIT  = 1;
  localparam int OSCSW_SWR_BIT  = 0;
  // clock divisor field positions
  localparam int OSCSW_ROI_BIT  = 15;
  localparam int OSCSW_RAT_LSB  = 12;
  localparam int OSCSW_RAE_BIT  = 11;
  localparam int OSCSW_RCP_LSB  = 8;
  localparam int OSCSW_VCO_LSB  = 6;
  localparam int OSCSW_PRE_LSB  = 0;
  // reset values
  localparam logic [2:0] OSCSW_RAT_RST = 3'h3;
  localparam logic [2:0] OSCSW_RCP_RST = 3'h0;
  localparam logic [1:0] OSCSW_VCO_RST = 2'h1;
  localparam logic [1:0] OSCSW_VCO_RSV = 2'h2;
  localparam logic [4:0] OSCSW_PRE_RST = 5'h00;
  localparam logic [8:0] OSCSW_FBM_RST = 9'h030;
  localparam logic [5:0] OSCSW_TRM_RST = 6'h00;
  // timing: settle count in new-clock cycles
  localparam logic [3:0] OSCSW_SETTLE_CYC = 4'hA;
  // source encodings
  typedef enum logic [2:0] {
    OSCSW_SRC_FRC    = 3'h0,
    OSCSW_SRC_FAST_RC_WITH_PLL = 3'h1,
    OSCSW_SRC_PRI    = 3'h2,
    OSCSW_SRC_PRIPLL = 3'h3,
    OSCSW_SRC_SEC    = 3'h4,
    OSCSW_SRC_LOW_POWER_RC_OSC   = 3'h5,
    OSCSW_SRC_FRC16  = 3'h6,
    OSCSW_SRC_FRCN   = 3'h7
  } oscsw_src_t;
  // switch sequencer states, gray along the path
  typedef enum logic [2:0] {
    OSCSW_IDLE   = 3'b000,
    OSCSW_CHECK  = 3'b001,
    OSCSW_START  = 3'b011,
    OSCSW_SETTLE = 3'b010,
    OSCSW_COMMIT = 3'b110
  } oscsw_st_t;
  // fuse straps
  typedef struct packed {
    logic       switching_disable_fuse;
    logic       freeze_fuse;
    oscsw_src_t reset_source_fuse;
    logic [1:0] primary_submode_fuse;
    logic       wdt_enable;
  } oscsw_fuse_t;
  // oscillator readiness, lock, new-clock tick, clock fail and interrupt from the analog side
  typedef struct packed {
    logic pri_ready;
    logic sec_ready;
    logic pll_locked;
    logic new_clk_tick;
    logic clock_fail;
    logic irq;
  } oscsw_ana_t;
  // oscillator and divider controls driven out
  typedef struct packed {
    logic       fast_rc_en;
    logic       low_power_rc_osc_en;
    logic       pri_en;
    logic       sec_en;
    logic       pll_en;
    oscsw_src_t sys_src;
    logic [1:0] pri_submode;
    logic [2:0] proc_ratio;
    logic [2:0] rc_postscale;
    logic [1:0] vco_out_divider;
    logic [4:0] phase_input_divider;
    logic [8:0] feedback_multiplier;
    logic [5:0] rc_trim;
  } oscsw_ctl_t;
endpackage

// >>> oscsw_ctrl_tb.sv
// Purpose: self-checking bench for the oscillator switch and divider control block
// Assumes: apb slave answers after a wait state; the bench waits for pready until the 30000-cycle hang guard ends the run
// Notes:   integer register model; second run with switching disabled and freeze fuse set
`timescale 1ns/1ps
`default_nettype none
module oscsw_ctrl_tb;
  import oscsw_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  oscsw_fuse_t fuse;
  oscsw_ana_t  ana;
  oscsw_ctl_t  ctl;
  int          bad_count;
  int          compares;
  int          cycles;
  int          e_div;
  int          e_sec;
  int          e_frz;
  int          frozen;
  int          src;
  logic [31:0] rd_data;
  logic        rd_err;
  logic [31:0] v;

  oscsw_ctrl oscsw_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .fuse(fuse),
    .ana(ana), .ctl(ctl));

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  // hang guard
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      bad_count++;
      $display("ERROR %0t timeout", $time);
      finish_test();
    end
  end

  task automatic finish_test();
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk_reg(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd_data, exp, what);
  endtask

  task automatic unlock(input logic [1:0] bytes);
    apb(1'b1, OSCSW_UNLOCK_OFF, OSCSW_UNLOCK_KEY | {30'h0, bytes});
  endtask

  // divisor write mirrored into the model; reserved vco code keeps the old field
  task automatic wr_div(input logic [31:0] d);
    apb(1'b1, OSCSW_CLK_DIV_OFF, d);
    if (frozen == 0)
      e_div = (d[7:6] != OSCSW_VCO_RSV) ? (d & 32'hFFDF) : ((d & 32'hFF1F) | (e_div & 32'h00C0));
    else
      e_div = (d & 32'hF800) | (e_div & 32'h07DF);
  endtask

  function automatic logic [31:0] ctrl_val(input int cur, input int nxt, input int lk, input int cf, input int swr);
    return 32'((cur << OSCSW_CUR_LSB) | (nxt << OSCSW_NXT_LSB) | (e_frz << OSCSW_FRZ_BIT) | (lk << OSCSW_LCK_BIT)
      | (cf << OSCSW_CF_BIT) | (e_sec << OSCSW_SEC_BIT) | swr);
  endfunction

  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      ana.new_clk_tick <= 1'b1;
      repeat (2) @(posedge pclk);
      ana.new_clk_tick <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask

  task automatic wait_swr0();
    int n;
    n = 0;
    apb(1'b0, OSCSW_OSC_CTRL_OFF, 32'h0);
    while (rd_data[0] !== 1'b0 && n < 100)
    begin
      apb(1'b0, OSCSW_OSC_CTRL_OFF, 32'h0);
      n++;
    end
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  task automatic switch_to(input int nxt);
    unlock(2'h2);
    apb(1'b1, OSCSW_OSC_CTRL_OFF, 32'(nxt << OSCSW_NXT_LSB));
    unlock(2'h1);
    apb(1'b1, OSCSW_OSC_CTRL_OFF, 32'(3));
  endtask

  // main sequence
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    ana = '0;
    fuse = '0;
    fuse.reset_source_fuse = OSCSW_SRC_FRC;
    fuse.primary_submode_fuse = 2'h1;
    fuse.wdt_enable = 1'b1;
    bad_count = 0;
    compares = 0;
    cycles = 0;
    e_div = 32'h3040;
    e_sec = 0;
    e_frz = 0;
    frozen = 0;
    void'($urandom(32'hEC7F53D0));
    do_reset();
    chk_reg(OSCSW_CLK_DIV_OFF, 32'h0000_3040, "div reset");
    chk_reg(OSCSW_PLL_FBD_OFF, 32'h0000_0030, "fbd reset");
    chk_reg(OSCSW_RC_TRIM_OFF, 32'h0, "trim reset");
    chk_reg(OSCSW_OSC_CTRL_OFF, ctrl_val(0, 0, 0, 0, 0), "ctrl reset");
    chk_reg(12'h0FC, 32'h0, "unmapped data");
    chk({31'h0, rd_err}, 32'h1, "unmapped err");
    // random divider, multiplier and trim values with boundary codes
    for (int i = 0; i < 6; i++)
    begin
      v = $urandom() & 32'h77DF;
      v[7:6] = (i == 0) ? OSCSW_VCO_RSV : v[7:6];
      wr_div(v);
      chk_reg(OSCSW_CLK_DIV_OFF, e_div, "div");
      v = (i == 1) ? 32'h1FF : ($urandom() & 32'h1FF);
      apb(1'b1, OSCSW_PLL_FBD_OFF, v);
      chk_reg(OSCSW_PLL_FBD_OFF, v, "fbd");
      chk(32'(ctl.feedback_multiplier), v, "ctl fbm");
      v = (i == 2) ? 32'h20 : ($urandom() & 32'h3F);
      apb(1'b1, OSCSW_RC_TRIM_OFF, v);
      chk_reg(OSCSW_RC_TRIM_OFF, v, "trim");
      chk(32'(ctl.rc_trim), v, "ctl trim");
      chk(32'({ctl.rc_postscale, ctl.vco_out_divider, ctl.phase_input_divider}), (32'((e_div >> 8) & 7) << 7)
        | (32'((e_div >> 6) & 3) << 5) | 32'(e_div & 32'h1F), "ctl div");
    end
    // recover on interrupt set, then clear
    wr_div(32'h0000_D840);
    repeat (2) @(posedge pclk);
    chk(32'(ctl.proc_ratio), 32'h5, "ctl ratio");
    ana.irq <= 1'b1;
    repeat (4) @(posedge pclk);
    ana.irq <= 1'b0;
    repeat (4) @(posedge pclk);
    chk_reg(OSCSW_CLK_DIV_OFF, 32'h0000_D040, "roi clears rae");
    wr_div(32'h0000_5840);
    ana.irq <= 1'b1;
    repeat (4) @(posedge pclk);
    ana.irq <= 1'b0;
    repeat (4) @(posedge pclk);
    chk_reg(OSCSW_CLK_DIV_OFF, 32'h0000_5840, "no roi keeps rae");
    // unlock arming and consumption
    apb(1'b1, OSCSW_OSC_CTRL_OFF, 32'h2);
    chk_reg(OSCSW_OSC_CTRL_OFF, ctrl_val(0, 0, 0, 0, 0), "locked write");
    chk(32'(ctl.sec_en), 32'h0, "sec off");
    unlock(2'h1);
    apb(1'b1, OSCSW_OSC_CTRL_OFF, 32'h2);
    e_sec = 1;
    apb(1'b1, OSCSW_OSC_CTRL_OFF, 32'h0);
    chk_reg(OSCSW_OSC_CTRL_OFF, ctrl_val(0, 0, 0, 0, 0), "one write per unlock");
    chk(32'(ctl.sec_en), 32'h1, "sec on");
    // clock fail set, then switch to primary with start-up and settle gates
    ana.clock_fail <= 1'b1;
    repeat (4) @(posedge pclk);
    ana.clock_fail <= 1'b0;
    repeat (4) @(posedge pclk);
    chk_reg(OSCSW_OSC_CTRL_OFF, ctrl_val(0, 0, 0, 1, 0), "cf set");
    switch_to(2);
    repeat (20) @(posedge pclk);
    chk_reg(OSCSW_OSC_CTRL_OFF, ctrl_val(0, 2, 0, 0, 1), "switch pending");
    ticks(12);
    chk_reg(OSCSW_OSC_CTRL_OFF, ctrl_val(0, 2, 0, 0, 1), "crystal wait");
    ana.pri_ready <= 1'b1;
    repeat (8) @(posedge pclk);
    ticks(9);
    repeat (10) @(posedge pclk);
    chk_reg(OSCSW_OSC_CTRL_OFF, ctrl_val(0, 2, 0, 0, 1), "settle nine");
    ticks(1);
    wait_swr0();
    chk(rd_data, ctrl_val(2, 2, 0, 0, 0), "switch done");
    chk(32'(ctl.sys_src), 32'h2, "sys src");
    chk(32'({ctl.pri_en, ctl.fast_rc_en, ctl.low_power_rc_osc_en, ctl.sec_en}), 32'hB, "osc enables");
    chk(32'(ctl.pri_submode), 32'h1, "submode");
    // redundant request aborts at once
    unlock(2'h1);
    apb(1'b1, OSCSW_OSC_CTRL_OFF, 32'h3);
    repeat (10) @(posedge pclk);
    chk_reg(OSCSW_OSC_CTRL_OFF, ctrl_val(2, 2, 0, 0, 0), "redundant");
    // pll source waits for lock; primary to primary pll never crosses the fast rc pll mode
    switch_to(3);
    ticks(12);
    chk_reg(OSCSW_OSC_CTRL_OFF, ctrl_val(2, 3, 0, 0, 1), "lock wait");
    ana.pll_locked <= 1'b1;
    repeat (8) @(posedge pclk);
    ticks(10);
    wait_swr0();
    chk(rd_data, ctrl_val(3, 3, 1, 0, 0), "pll switch");
    chk(32'({ctl.pll_en, ctl.sys_src}), 32'hB, "pll sys src");
    // second run: switching disabled, freeze fuse set
    ana <= '0;
    src = $urandom_range(7, 0);
    fuse.switching_disable_fuse <= 1'b1;
    fuse.freeze_fuse <= 1'b1;
    fuse.reset_source_fuse <= oscsw_src_t'(src);
    do_reset();
    e_sec = 0;
    e_div = 32'h3040;
    chk_reg(OSCSW_OSC_CTRL_OFF, ctrl_val(src, src, 0, 0, 0), "fuse source");
    chk(32'(ctl.sys_src), 32'(src), "fuse sys src");
    unlock(2'h1);
    apb(1'b1, OSCSW_OSC_CTRL_OFF, 32'h81);
    e_frz = 1;
    frozen = 1;
    chk_reg(OSCSW_OSC_CTRL_OFF, ctrl_val(src, src, 0, 0, 0), "request held low");
    wr_div(32'h0000_1234);
    chk_reg(OSCSW_CLK_DIV_OFF, e_div, "frozen div");
    finish_test();
  end
endmodule
`default_nettype wire
